/* design/exec_map.svh */
/*
  Register offsets, status bit positions, instruction word fields and reset
  values of the instruction execute block.
  Assumes a 32-bit AHB-Lite bus with byte addresses decoded in haddr[7:0].
*/
`ifndef EXEC_MAP_SVH
`define EXEC_MAP_SVH

`define REG_INSTR 8'h00
`define REG_ACC 8'h04
`define REG_STATUS 8'h08
`define REG_PC 8'h0C
`define REG_MEM_SEL 8'h10
`define REG_MEM_DATA 8'h14
`define REG_STACK 8'h18

`define FLD_OP_LSB 0
`define FLD_OP_W 5
`define FLD_MADDR_LSB 8
`define FLD_IMM_LSB 16
`define FLD_JADDR_LSB 16

`define ST_CARRY 0
`define ST_HBC 1
`define ST_ZERO 2
`define ST_OV 3
`define ST_PDF 4
`define ST_WTO 5
`define ST_GIE 6
`define ST_BUSY 8
`define ST_HALTED 9
`define ST_CYC_LSB 10

`define ACC_RST 8'h00
`define INSTR_RST 32'h0000_0000
`define BCD_DIGIT_MAX 4'h9
`define BCD_LO_ADJ 9'h006
`define BCD_HI_ADJ 9'h060
`define CYC_ONE 2'h1
`define CYC_TWO 2'h2

`endif

/* design/exec_pkg.sv */
/*
  Types of the instruction execute block: operation codes and sequencer states.
  Assumes the offsets and fields of exec_map.svh.
*/
package exec_pkg;

  typedef enum logic [4:0] {
    op_nop = 5'h00,
    invert_to_accum_op = 5'h01,
    bcd_adjust_op = 5'h02,
    dec_mem_op = 5'h03,
    decrement_to_accum_op = 5'h04,
    inc_mem_op = 5'h05,
    increment_to_accum_op = 5'h06,
    power_down_op = 5'h07,
    unconditional_jump = 5'h08,
    mov_acc_from_mem_op = 5'h09,
    mov_acc_imm_op = 5'h0A,
    mov_mem_from_acc_op = 5'h0B,
    or_acc_mem_op = 5'h0C,
    or_acc_imm_op = 5'h0D,
    or_to_memory_op = 5'h0E,
    return_op = 5'h0F,
    return_imm_op = 5'h10,
    interrupt_return = 5'h11,
    rotate_left_op = 5'h12,
    rotate_left_acc_op = 5'h13,
    rotate_left_thru_carry_op = 5'h14,
    rotate_left_thru_carry_acc_op = 5'h15,
    rotate_right_op = 5'h16,
    rotate_right_acc_op = 5'h17,
    rotate_right_thru_carry_op = 5'h18,
    rotate_right_thru_carry_acc_op = 5'h19,
    subtract_with_borrow_op = 5'h1A,
    subtract_with_borrow_mem_op = 5'h1B,
    decrement_skip_zero_op = 5'h1C
  } op_t;

  typedef enum logic [4:0] {
    st_idle = 5'b00001,
    st_read = 5'b00010,
    st_exec = 5'b00100,
    st_dummy = 5'b01000,
    st_halt = 5'b10000
  } state_t;

endpackage

/* design/exec_dmem.sv */
/*
  Small data memory with one write port and two read ports whose data come
  out of registers one clock after the address.
  Assumes a single clock and an active-low asynchronous reset.
*/
`timescale 1ns/100ps
module exec_dmem #(
  parameter int DW = 8,
  parameter int AW = 4
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  // Read ports
  input wire logic [AW-1:0] raddr_a,
  output logic [DW-1:0] rdata_a,
  input wire logic [AW-1:0] raddr_b,
  output logic [DW-1:0] rdata_b
);

  typedef struct packed {
    logic [(1<<AW)-1:0][DW-1:0] mem;
    logic [DW-1:0] rd_a;
    logic [DW-1:0] rd_b;
  } dmem_t;

  dmem_t d_r, d_nxt;

  always_comb
  begin
    d_nxt = d_r;
    d_nxt.rd_a = d_r.mem[raddr_a];
    d_nxt.rd_b = d_r.mem[raddr_b];
    if (we)
    begin
      d_nxt.mem[waddr] = wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      d_r <= '0;
    end
    else
    begin
      d_r <= d_nxt;
    end
  end

  assign rdata_a = d_r.rd_a;
  assign rdata_b = d_r.rd_b;

endmodule // exec_dmem

/* design/mcu_instruction_execute.sv */
/*
  Execute stage of an 8-bit accumulator machine, driven over AHB-Lite.
  Software loads an instruction word; the block reads its operand, executes,
  and updates accumulator, data memory, program counter, stack and flags.
  Assumes one 125 MHz clock, single-word AHB-Lite transfers, and wake and
  interrupt request pins that are asynchronous to hclk.
*/
// The placing of the registers and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
`include "exec_map.svh"
module mcu_instruction_execute
  import exec_pkg::*;
#(
  parameter int PC_W = 11,
  parameter int STACK_DEPTH = 4,
  parameter int MEM_AW = 4,
  parameter logic [10:0] IRQ_VECTOR = 11'h004
)(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Pins
  input wire logic wake_pin,
  input wire logic irq_pin,
  output logic sys_clk_en,
  output logic watchdog_clear
);

  localparam int SP_W = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;

  typedef struct packed {
    state_t state;
    logic [31:0] instr;
    logic [7:0] acc;
    logic carry;
    logic half_byte_carry_flag;
    logic zero;
    logic ov;
    logic power_down_flag;
    logic watchdog_expiry_flag;
    logic global_irq_enable;
    logic [PC_W-1:0] pc;
    logic [STACK_DEPTH-1:0][PC_W-1:0] stk;
    logic [SP_W-1:0] sp;
    logic [MEM_AW-1:0] mem_sel;
    logic [1:0] last_cyc;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic mem_we;
    logic [MEM_AW-1:0] mem_wa;
    logic [7:0] mem_wd;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic sys_clk_en;
    logic watchdog_clear;
    logic wake_s1;
    logic wake_s2;
    logic irq_s1;
    logic irq_s2;
  } core_t;

  core_t s_r, s_nxt;

  logic [7:0] mem_rd_a, mem_rd_b;
  op_t op;
  logic ex;
  logic [7:0] m, imm, res;
  logic to_acc, to_mem, upd_z, two, halt;
  logic [8:0] sub_full, bcd_sum;
  logic [4:0] sub_low;
  logic lo_adj, hi_adj;
  logic [SP_W-1:0] pop_idx;
  logic [PC_W-1:0] pc_inc;
  logic [31:0] rdv;
  logic bus_ok;

  exec_dmem #(
    .DW(8),
    .AW(MEM_AW)
  ) exec_dmem_i (
    .clk(hclk),
    .rst_n(hresetn),
    .we(s_r.mem_we),
    .waddr(s_r.mem_wa),
    .wdata(s_r.mem_wd),
    .raddr_a(s_r.mem_sel),
    .rdata_a(mem_rd_a),
    .raddr_b(s_r.instr[`FLD_MADDR_LSB +: MEM_AW]),
    .rdata_b(mem_rd_b)
  );

  // Operand decode and datapath terms; m and imm eight bits wide, sub_full and bcd_sum nine bits
  assign op = op_t'(s_r.instr[`FLD_OP_LSB +: `FLD_OP_W]);
  assign ex = (s_r.state == st_exec);
  assign m = mem_rd_b;
  assign imm = s_r.instr[`FLD_IMM_LSB +: 8];
  assign pop_idx = s_r.sp - 1'b1;
  assign pc_inc = s_r.pc + 1'b1;
  assign sub_full = {1'b0, s_r.acc} - {1'b0, m} - {8'h00, ~s_r.carry};
  assign sub_low = {1'b0, s_r.acc[3:0]} - {1'b0, m[3:0]} - {4'h0, ~s_r.carry};
  assign lo_adj = (s_r.acc[3:0] > `BCD_DIGIT_MAX) || s_r.half_byte_carry_flag;
  assign hi_adj = (s_r.acc[7:4] > `BCD_DIGIT_MAX) || s_r.carry;
  assign bcd_sum = {1'b0, s_r.acc} + (lo_adj ? `BCD_LO_ADJ : 9'h000)
                 + (hi_adj ? `BCD_HI_ADJ : 9'h000);
  assign bus_ok = hsel && htrans[1] && hready && (haddr[31:8] == 24'h000000);

  always_comb
  begin
    s_nxt = s_r;
    res = 8'h00;
    to_acc = 1'b0;
    to_mem = 1'b0;
    upd_z = 1'b0;
    two = 1'b0;
    halt = 1'b0;
    rdv = 32'h0000_0000;
    s_nxt.watchdog_clear = 1'b0;
    s_nxt.mem_we = 1'b0;
    s_nxt.wake_s1 = wake_pin;
    s_nxt.wake_s2 = s_r.wake_s1;
    s_nxt.irq_s1 = irq_pin;
    s_nxt.irq_s2 = s_r.irq_s1;
    // Read data are registered in the address phase
    if (haddr[7:0] == `REG_INSTR)
      rdv = s_r.instr;
    else if (haddr[7:0] == `REG_ACC)
      rdv[7:0] = s_r.acc;
    else if (haddr[7:0] == `REG_STATUS)
    begin
      rdv[`ST_CARRY] = s_r.carry;
      rdv[`ST_HBC] = s_r.half_byte_carry_flag;
      rdv[`ST_ZERO] = s_r.zero;
      rdv[`ST_OV] = s_r.ov;
      rdv[`ST_PDF] = s_r.power_down_flag;
      rdv[`ST_WTO] = s_r.watchdog_expiry_flag;
      rdv[`ST_GIE] = s_r.global_irq_enable;
      rdv[`ST_BUSY] = (s_r.state != st_idle) && (s_r.state != st_halt);
      rdv[`ST_HALTED] = (s_r.state == st_halt);
      rdv[`ST_CYC_LSB +: 2] = s_r.last_cyc;
    end
    else if (haddr[7:0] == `REG_PC)
      rdv[PC_W-1:0] = s_r.pc;
    else if (haddr[7:0] == `REG_MEM_SEL)
      rdv[MEM_AW-1:0] = s_r.mem_sel;
    else if (haddr[7:0] == `REG_MEM_DATA)
      rdv[7:0] = mem_rd_a;
    else if (haddr[7:0] == `REG_STACK)
      rdv[PC_W-1:0] = s_r.stk[pop_idx];
    // Unmapped reads return zero instead of stale data
    if (hsel && htrans[1] && hready && !hwrite)
      s_nxt.hrdata = bus_ok ? rdv : 32'h0000_0000;
    s_nxt.wr_pend = bus_ok && hwrite;
    if (bus_ok)
      s_nxt.wr_addr = haddr[7:0];
    // Data phase writes
    if (s_r.wr_pend)
    begin
      if (s_r.wr_addr == `REG_INSTR)
      begin
        if (s_r.state == st_idle)
        begin
          s_nxt.instr = hwdata;
          s_nxt.state = st_read;
        end
      end
      else if (s_r.wr_addr == `REG_ACC)
        s_nxt.acc = hwdata[7:0];
      else if (s_r.wr_addr == `REG_STATUS)
      begin
        s_nxt.carry = hwdata[`ST_CARRY];
        s_nxt.half_byte_carry_flag = hwdata[`ST_HBC];
        s_nxt.zero = hwdata[`ST_ZERO];
        s_nxt.ov = hwdata[`ST_OV];
        s_nxt.power_down_flag = hwdata[`ST_PDF];
        s_nxt.watchdog_expiry_flag = hwdata[`ST_WTO];
        s_nxt.global_irq_enable = hwdata[`ST_GIE];
      end
      else if (s_r.wr_addr == `REG_PC)
        s_nxt.pc = hwdata[PC_W-1:0];
      else if (s_r.wr_addr == `REG_MEM_SEL)
        s_nxt.mem_sel = hwdata[MEM_AW-1:0];
      else if (s_r.wr_addr == `REG_MEM_DATA)
      begin
        s_nxt.mem_we = 1'b1;
        s_nxt.mem_wa = s_r.mem_sel;
        s_nxt.mem_wd = hwdata[7:0];
      end
      else if (s_r.wr_addr == `REG_STACK)
      begin
        s_nxt.stk[s_r.sp] = hwdata[PC_W-1:0];
        s_nxt.sp = s_r.sp + 1'b1;
      end
    end
    // Sequencer
    case (s_r.state)
      st_read:
        s_nxt.state = st_exec;
      st_exec:
      begin
        s_nxt.pc = pc_inc;
        case (op)
          invert_to_accum_op:
          begin
            res = ~m;
            to_acc = 1'b1;
            upd_z = 1'b1;
          end
          bcd_adjust_op:
          begin
            res = bcd_sum[7:0];
            to_mem = 1'b1;
            s_nxt.carry = hi_adj | bcd_sum[8];
          end
          dec_mem_op, decrement_to_accum_op:
          begin
            res = m - 8'h01;
            to_mem = (op == dec_mem_op);
            to_acc = (op == decrement_to_accum_op);
            upd_z = 1'b1;
          end
          inc_mem_op, increment_to_accum_op:
          begin
            res = m + 8'h01;
            to_mem = (op == inc_mem_op);
            to_acc = (op == increment_to_accum_op);
            upd_z = 1'b1;
          end
          power_down_op:
          begin
            halt = 1'b1;
            s_nxt.sys_clk_en = 1'b0;
            s_nxt.watchdog_clear = 1'b1;
            s_nxt.power_down_flag = 1'b1;
            s_nxt.watchdog_expiry_flag = 1'b0;
          end
          unconditional_jump:
          begin
            s_nxt.pc = s_r.instr[`FLD_JADDR_LSB +: PC_W];
            two = 1'b1;
          end
          mov_acc_from_mem_op, mov_acc_imm_op:
          begin
            res = (op == mov_acc_imm_op) ? imm : m;
            to_acc = 1'b1;
          end
          mov_mem_from_acc_op:
          begin
            res = s_r.acc;
            to_mem = 1'b1;
          end
          or_acc_mem_op, or_acc_imm_op, or_to_memory_op:
          begin
            res = s_r.acc | ((op == or_acc_imm_op) ? imm : m);
            to_mem = (op == or_to_memory_op);
            to_acc = (op != or_to_memory_op);
            upd_z = 1'b1;
          end
          return_op, return_imm_op:
          begin
            s_nxt.pc = s_r.stk[pop_idx];
            s_nxt.sp = pop_idx;
            res = imm;
            to_acc = (op == return_imm_op);
            two = 1'b1;
          end
          interrupt_return:
          begin
            two = 1'b1;
            if (s_r.irq_s2)
            begin
              // Pending request is served first; return address stays stacked
              s_nxt.pc = IRQ_VECTOR[PC_W-1:0];
              s_nxt.global_irq_enable = 1'b0;
            end
            else
            begin
              s_nxt.pc = s_r.stk[pop_idx];
              s_nxt.sp = pop_idx;
              s_nxt.global_irq_enable = 1'b1;
            end
          end
          rotate_left_op, rotate_left_acc_op:
          begin
            res = {m[6:0], m[7]};
            to_mem = (op == rotate_left_op);
            to_acc = (op == rotate_left_acc_op);
          end
          rotate_left_thru_carry_op, rotate_left_thru_carry_acc_op:
          begin
            res = {m[6:0], s_r.carry};
            s_nxt.carry = m[7];
            to_mem = (op == rotate_left_thru_carry_op);
            to_acc = (op == rotate_left_thru_carry_acc_op);
          end
          rotate_right_op, rotate_right_acc_op:
          begin
            res = {m[0], m[7:1]};
            to_mem = (op == rotate_right_op);
            to_acc = (op == rotate_right_acc_op);
          end
          rotate_right_thru_carry_op, rotate_right_thru_carry_acc_op:
          begin
            res = {s_r.carry, m[7:1]};
            s_nxt.carry = m[0];
            to_mem = (op == rotate_right_thru_carry_op);
            to_acc = (op == rotate_right_thru_carry_acc_op);
          end
          subtract_with_borrow_op, subtract_with_borrow_mem_op:
          begin
            res = sub_full[7:0];
            s_nxt.carry = ~sub_full[8];
            s_nxt.half_byte_carry_flag = ~sub_low[4];
            s_nxt.ov = (s_r.acc[7] ^ m[7]) & (s_r.acc[7] ^ sub_full[7]);
            upd_z = 1'b1;
            to_mem = (op == subtract_with_borrow_mem_op);
            to_acc = (op == subtract_with_borrow_op);
          end
          decrement_skip_zero_op:
          begin
            res = m - 8'h01;
            to_mem = 1'b1;
            if (res == 8'h00)
            begin
              s_nxt.pc = s_r.pc + 2'h2;
              two = 1'b1;
            end
          end
          default:
            res = 8'h00;
        endcase
        if (to_acc)
          s_nxt.acc = res;
        if (to_mem)
        begin
          s_nxt.mem_we = 1'b1;
          s_nxt.mem_wa = s_r.instr[`FLD_MADDR_LSB +: MEM_AW];
          s_nxt.mem_wd = res;
        end
        if (upd_z)
          s_nxt.zero = (res == 8'h00);
        s_nxt.last_cyc = two ? `CYC_TWO : `CYC_ONE;
        s_nxt.state = halt ? st_halt : (two ? st_dummy : st_idle);
      end
      st_dummy:
        s_nxt.state = st_idle;
      st_halt:
      begin
        if (s_r.wake_s2)
        begin
          s_nxt.state = st_idle;
          s_nxt.sys_clk_en = 1'b1;
        end
      end
      default:
      begin
        if (s_r.state != st_idle)
          s_nxt.state = st_idle;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_r <= '0;
      s_r.state <= st_idle;
      s_r.instr <= `INSTR_RST;
      s_r.acc <= `ACC_RST;
      s_r.hreadyout <= 1'b1;
      s_r.sys_clk_en <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign hreadyout = s_r.hreadyout;
  assign hresp = s_r.hresp;
  assign hrdata = s_r.hrdata;
  assign sys_clk_en = s_r.sys_clk_en;
  assign watchdog_clear = s_r.watchdog_clear;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_invert;
    ex && op == invert_to_accum_op |=> s_r.acc == ~$past(mem_rd_b)
      && s_r.zero == (s_r.acc == 8'h00) && !s_r.mem_we;
  endproperty
  a_invert: assert property (p_invert) else $error("invert result wrong");

  property p_bcd_value;
    ex && op == bcd_adjust_op && s_r.acc == 8'h0A && !s_r.carry
      && !s_r.half_byte_carry_flag |=> s_r.mem_we && s_r.mem_wd == 8'h10 && !s_r.carry;
  endproperty
  a_bcd_value: assert property (p_bcd_value) else $error("decimal adjust wrong");

  property p_bcd_flags;
    ex && op == bcd_adjust_op |=> $stable({s_r.zero, s_r.ov, s_r.half_byte_carry_flag});
  endproperty
  a_bcd_flags: assert property (p_bcd_flags) else $error("decimal adjust flags");

  property p_dec_acc;
    ex && op == decrement_to_accum_op |=> s_r.acc == $past(mem_rd_b) - 8'h01 && !s_r.mem_we;
  endproperty
  a_dec_acc: assert property (p_dec_acc) else $error("decrement to acc wrong");

  property p_inc_mem;
    ex && op == inc_mem_op |=> s_r.mem_we && s_r.mem_wd == $past(mem_rd_b) + 8'h01
      && $stable(s_r.acc);
  endproperty
  a_inc_mem: assert property (p_inc_mem) else $error("increment memory wrong");

  property p_halt;
    ex && op == power_down_op |=> s_r.state == st_halt && s_r.power_down_flag
      && !s_r.watchdog_expiry_flag && s_r.watchdog_clear && !s_r.sys_clk_en
      ##1 !s_r.watchdog_clear;
  endproperty
  a_halt: assert property (p_halt) else $error("power down entry wrong");

  property p_jump;
    ex && op == unconditional_jump |=> s_r.state == st_dummy
      && s_r.pc == $past(s_r.instr[`FLD_JADDR_LSB +: PC_W]) ##1 s_r.state == st_idle;
  endproperty
  a_jump: assert property (p_jump) else $error("jump wrong");

  property p_mov_flags;
    ex && (op == mov_acc_from_mem_op || op == mov_acc_imm_op || op == mov_mem_from_acc_op)
      |=> $stable({s_r.carry, s_r.zero, s_r.ov, s_r.half_byte_carry_flag});
  endproperty
  a_mov_flags: assert property (p_mov_flags) else $error("move changed flags");

  property p_iret;
    ex && op == interrupt_return && !s_r.irq_s2 |=> s_r.global_irq_enable
      && s_r.state == st_dummy && s_r.sp == $past(pop_idx);
  endproperty
  a_iret: assert property (p_iret) else $error("interrupt return wrong");

  property p_rot_left;
    ex && op == rotate_left_acc_op |=> s_r.acc == {$past(mem_rd_b[6:0]), $past(mem_rd_b[7])};
  endproperty
  a_rot_left: assert property (p_rot_left) else $error("rotate left wrong");

  property p_sbc_borrow;
    ex && op == subtract_with_borrow_op && s_r.carry && s_r.acc < mem_rd_b |=> !s_r.carry;
  endproperty
  a_sbc_borrow: assert property (p_sbc_borrow) else $error("borrow carry wrong");

  property p_skip;
    ex && op == decrement_skip_zero_op && mem_rd_b == 8'h01 |=> s_r.state == st_dummy
      && s_r.pc == $past(s_r.pc) + 2'h2 && s_r.mem_wd == 8'h00;
  endproperty
  a_skip: assert property (p_skip) else $error("skip wrong");

  c_halt_wake: cover property (s_r.state == st_halt ##[1:50] s_r.state == st_idle);
  c_skip: cover property (ex && op == decrement_skip_zero_op && mem_rd_b == 8'h01);
  c_iret_pend: cover property (ex && op == interrupt_return && s_r.irq_s2);
  c_jump: cover property (ex && op == unconditional_jump);

endmodule // mcu_instruction_execute

/* bench/pin_source.sv */
/*
  Model of the parts outside the block that drive its wake and interrupt pins.
  Assumes the bench calls its tasks from a process synchronised to clk.
*/
`timescale 1ns/100ps
module pin_source (
  // Clock
  input wire logic clk,
  // Wake side
  input wire logic sys_clk_en,
  output logic wake_pin,
  // Interrupt side
  output logic irq_pin
);
  initial
  begin
    wake_pin = 1'b0;
    irq_pin = 1'b0;
  end

  // Level held long enough to pass the two-stage synchroniser
  task automatic set_irq(input logic v);
    @(posedge clk);
    irq_pin <= v;
    repeat (3) @(posedge clk);
  endtask

  // Wake is a level held until the clock comes back, then released
  task automatic wake();
    int n;
    @(posedge clk);
    wake_pin <= 1'b1;
    n = 0;
    while (sys_clk_en !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    wake_pin <= 1'b0;
  endtask
endmodule // pin_source

/* bench/tb_mcu_instruction_execute.sv */
/*
  Self-checking bench of the instruction execute block, one task per scenario.
  Assumes the register map header and the pin source model.
*/
`timescale 1ns/100ps
`include "exec_map.svh"
module tb_mcu_instruction_execute
  import exec_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic hready, hreadyout, hresp, wake_pin, irq_pin, sys_clk_en, watchdog_clear;
  int num_errors = 0;
  int checks = 0;
  int clear_seen = 0;

  always #4 hclk = ~hclk;
  assign hready = hreadyout;
  // Counted away from the launching edge so the one-cycle pulse is seen settled
  always @(negedge hclk) if (watchdog_clear === 1'b1) clear_seen++;

  mcu_instruction_execute mcu_instruction_execute_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .wake_pin(wake_pin),
    .irq_pin(irq_pin), .sys_clk_en(sys_clk_en), .watchdog_clear(watchdog_clear));

  pin_source pin_source_i (.clk(hclk), .sys_clk_en(sys_clk_en), .wake_pin(wake_pin),
    .irq_pin(irq_pin));

  task automatic final_report();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("wrong value at %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wait_rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hreadyout !== 1'b1 && n < 40);
    if (hreadyout !== 1'b1)
    begin
      num_errors++;
      final_report();
    end
  endtask

  // One single AHB-Lite transfer; read data lands in rd
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask

  // Issue an instruction and poll until no longer busy (idle or halted); rd ends holding the status word
  task automatic run(input op_t op, input logic [10:0] imm);
    int n;
    bus(1'b1, `REG_INSTR, {5'h0, imm, 8'h03, 3'h0, op});
    n = 0;
    do
    begin
      bus(1'b0, `REG_STATUS, 32'h0);
      n++;
    end
    while (rd[`ST_BUSY] !== 1'b0 && n < 10);
    if (rd[`ST_BUSY] !== 1'b0)
    begin
      num_errors++;
      final_report();
    end
  endtask

  task automatic step(input op_t op, input logic [10:0] imm, input logic [7:0] a, s, m, ea,
    em, input logic [11:0] es, input logic [10:0] epc);
    bus(1'b1, `REG_ACC, {24'h0, a});
    bus(1'b1, `REG_STATUS, {24'h0, s});
    bus(1'b1, `REG_MEM_SEL, 32'h3);
    bus(1'b1, `REG_MEM_DATA, {24'h0, m});
    bus(1'b1, `REG_PC, 32'h10);
    run(op, imm);
    chk(rd & 32'hFFF, {20'h0, es});
    bus(1'b0, `REG_ACC, 32'h0);
    chk(rd, {24'h0, ea});
    bus(1'b0, `REG_PC, 32'h0);
    chk(rd, {21'h0, epc});
    bus(1'b0, `REG_MEM_DATA, 32'h0);
    chk(rd, {24'h0, em});
  endtask

  task automatic t_alu();
    step(invert_to_accum_op, 11'h0, 8'h0, 8'h0, 8'hFF, 8'h0, 8'hFF, 12'h404, 11'h11);
    step(bcd_adjust_op, 11'h0, 8'hAB, 8'h4, 8'h0, 8'hAB, 8'h11, 12'h405, 11'h11);
    step(bcd_adjust_op, 11'h0, 8'h15, 8'h2, 8'h0, 8'h15, 8'h1B, 12'h402, 11'h11);
    step(bcd_adjust_op, 11'h0, 8'h0A, 8'h0, 8'h0, 8'h0A, 8'h10, 12'h400, 11'h11);
    step(dec_mem_op, 11'h0, 8'h0, 8'h4, 8'h0, 8'h0, 8'hFF, 12'h400, 11'h11);
    step(decrement_to_accum_op, 11'h0, 8'h0, 8'h0, 8'h1, 8'h0, 8'h1, 12'h404, 11'h11);
    step(inc_mem_op, 11'h0, 8'h0, 8'h0, 8'hFF, 8'h0, 8'h0, 12'h404, 11'h11);
    step(increment_to_accum_op, 11'h0, 8'h0, 8'h4, 8'h7F, 8'h80, 8'h7F, 12'h400, 11'h11);
  endtask

  task automatic t_rotate();
    logic [31:0] tab [8];
    tab = '{32'h12805501, 32'h13800180, 32'h34805500, 32'h35800080,
      32'h16015580, 32'h17018001, 32'h38015500, 32'h39010001};
    for (int i = 0; i < 8; i++)
      step(op_t'(tab[i][28:24]), 11'h0, 8'h55, 8'h0, tab[i][23:16], tab[i][15:8], tab[i][7:0],
        {2'h1, 9'h0, tab[i][29]}, 11'h11);
  endtask

  task automatic t_sbc();
    step(subtract_with_borrow_op, 11'h0, 8'h80, 8'h1, 8'h1, 8'h7F, 8'h1, 12'h409, 11'h11);
    step(subtract_with_borrow_op, 11'h0, 8'h10, 8'h1, 8'h20, 8'hF0, 8'h20, 12'h402, 11'h11);
    step(subtract_with_borrow_mem_op, 11'h0, 8'h5, 8'h0, 8'h4, 8'h5, 8'h0, 12'h407, 11'h11);
  endtask

  task automatic t_move_or();
    step(mov_acc_imm_op, 11'h5A, 8'h0, 8'hF, 8'h33, 8'h5A, 8'h33, 12'h40F, 11'h11);
    step(mov_mem_from_acc_op, 11'h0, 8'h5A, 8'hF, 8'h33, 8'h5A, 8'h5A, 12'h40F, 11'h11);
    step(or_acc_imm_op, 11'h0, 8'h0, 8'hB, 8'h33, 8'h0, 8'h33, 12'h40F, 11'h11);
    step(or_to_memory_op, 11'h0, 8'h50, 8'h4, 8'hA, 8'h50, 8'h5A, 12'h400, 11'h11);
  endtask

  task automatic t_flow();
    step(op_nop, 11'h0, 8'h12, 8'hF, 8'h34, 8'h12, 8'h34, 12'h40F, 11'h11);
    step(unconditional_jump, 11'h123, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 12'h800, 11'h123);
    bus(1'b1, `REG_STACK, 32'h55);
    step(return_imm_op, 11'h77, 8'h0, 8'h1, 8'h0, 8'h77, 8'h0, 12'h801, 11'h55);
    bus(1'b1, `REG_STACK, 32'h66);
    step(interrupt_return, 11'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 12'h840, 11'h66);
    step(decrement_skip_zero_op, 11'h0, 8'h0, 8'hB, 8'h1, 8'h0, 8'h0, 12'h80B, 11'h12);
    step(decrement_skip_zero_op, 11'h0, 8'h0, 8'hB, 8'h0, 8'h0, 8'hFF, 12'h40B, 11'h11);
    pin_source_i.set_irq(1'b1);
    bus(1'b1, `REG_STACK, 32'h77);
    step(interrupt_return, 11'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 12'h800, 11'h4);
    bus(1'b0, `REG_STACK, 32'h0);
    chk(rd, 32'h77);
    pin_source_i.set_irq(1'b0);
  endtask

  task automatic t_halt();
    step(power_down_op, 11'h0, 8'h12, 8'h20, 8'h34, 8'h12, 8'h34, 12'h610, 11'h11);
    chk({31'h0, sys_clk_en}, 32'h0);
    chk(clear_seen, 32'h1);
    pin_source_i.wake();
    bus(1'b0, `REG_STATUS, 32'h0);
    chk(rd & 32'h210, 32'h10);
    chk({31'h0, sys_clk_en}, 32'h1);
  endtask

  initial
  begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_alu();
    t_rotate();
    t_sbc();
    t_move_or();
    t_flow();
    t_halt();
    final_report();
  end
endmodule // tb_mcu_instruction_execute
